// [hw/swcw_top.sv]
// switch control front end: direct inputs, serial slave, watchdog, pwm, fault flags
`timescale 1ns/1ps
`default_nettype none

module swcw_top import swcw_pkg::*; #(
    parameter int unsigned SLEEP_CYC = SLEEP_DELAY_CYC,
    parameter int unsigned WDOG_CYC = WDOG_TIMEOUT_CYC,
    parameter int unsigned CLKMON_LIMIT = CLKMON_CYC
) (
    // system clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // control pins
    input wire logic i_direct_in_a,
    input wire logic i_direct_in_b,
    input wire logic [1:0] i_load_sel,
    input wire logic [1:0] i_load_sel_conn,
    input wire logic i_external_reset_n,
    input wire logic i_logic_supply_ok,
    input wire logic i_pwm_ext_clk,
    // fault sensors
    input wire swcw_chfault_t i_fault_a,
    input wire swcw_chfault_t i_fault_b,
    input wire swcw_supply_t i_supply,
    // serial link
    input wire logic i_sclk,
    input wire logic i_chip_select_n,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe_n,
    // power stage and flags
    output logic o_power_output_a,
    output logic o_power_output_b,
    output logic [1:0] o_motor_profile,
    output logic o_fault_flag_n_drv,
    output logic o_fault_flag_n_oe_n,
    output logic o_failsafe_flag_n_drv,
    output logic o_failsafe_flag_n_oe_n,
    output logic o_awake
);

    function automatic logic [14:0] clr_mask(input logic [3:0] sel);
        case (sel)
            RD_STATUS: clr_mask = CLR_STATUS;
            RD_FAULT_A: clr_mask = CLR_FAULT_A;
            RD_FAULT_B: clr_mask = CLR_FAULT_B;
            RD_DIAG_A: clr_mask = CLR_DIAG_A;
            RD_DIAG_B: clr_mask = CLR_DIAG_B;
            default: clr_mask = 15'h0000;
        endcase
    endfunction

    // ---- serial clock domain ----
    logic [3:0] bit_cnt_reg;
    logic [14:0] rx_shift_reg;
    logic [15:0] rx_hold_reg;
    logic rx_tog_reg;
    logic [4:0] tx_ptr_reg;
    logic [3:0] tx_idx;
    logic [15:0] tx_word_reg;

    // chip select high clears the bit position, so clock and data are ignored
    always_ff @(negedge i_sclk or posedge i_chip_select_n) begin
        if (i_chip_select_n) begin
            bit_cnt_reg <= 4'h0;
            rx_shift_reg <= 15'h0000;
        end else begin
            rx_shift_reg <= {rx_shift_reg[13:0], i_si};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    // every sixteenth bit completes a word; longer chains keep the word ending on the last multiple of sixteen bits
    always_ff @(negedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            rx_hold_reg <= 16'h0000;
            rx_tog_reg <= 1'b0;
        end else if (!i_chip_select_n && bit_cnt_reg == 4'hF) begin
            rx_hold_reg <= {rx_shift_reg, i_si};
            rx_tog_reg <= ~rx_tog_reg;
        end
    end

    // msb stands from select fall, later bits follow rising edges
    always_ff @(posedge i_sclk or posedge i_chip_select_n) begin
        if (i_chip_select_n) begin
            tx_ptr_reg <= 5'h00;
        end else if (tx_ptr_reg != 5'h10) begin
            tx_ptr_reg <= tx_ptr_reg + 5'h01;
        end
    end

    // tx_word_reg loads just after select fall and stays frozen for the rest of the frame, so the mux crosses safely
    assign tx_idx = (tx_ptr_reg == 5'h00) ? 4'hF : 4'(5'h10 - tx_ptr_reg);
    assign o_so = tx_word_reg[tx_idx];

    // ---- pin synchronisers ----
    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] meta_reg;
    logic [SYNC_W-1:0] sync_reg;
    logic dir_a_s, dir_b_s, rst_s, vdd_s, ext_clk_s, cs_n_s, rx_tog_s;
    logic [1:0] load_sel_s, load_conn_s;
    swcw_chfault_t flt_a_s, flt_b_s;
    swcw_supply_t sup_s;

    assign sync_in = {i_direct_in_a, i_direct_in_b, i_load_sel, i_load_sel_conn,
                      i_external_reset_n, i_logic_supply_ok, i_pwm_ext_clk,
                      i_fault_a, i_fault_b, i_supply, i_chip_select_n, rx_tog_reg};

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= SYNC_RST;
            sync_reg <= SYNC_RST;
        end else if (i_ce) begin
            meta_reg <= sync_in;
            sync_reg <= meta_reg;
        end
    end

    assign {dir_a_s, dir_b_s, load_sel_s, load_conn_s, rst_s, vdd_s, ext_clk_s,
            flt_a_s, flt_b_s, sup_s, cs_n_s, rx_tog_s} = sync_reg;

    // ---- frame events ----
    logic cs_prev_reg, rx_seen_reg, ext_prev_reg, dir_a_prev_reg, dir_b_prev_reg;
    logic cs_fall, commit, ext_edge, dir_rise;
    logic [3:0] rx_addr;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cs_prev_reg <= 1'b1;
            rx_seen_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
            dir_a_prev_reg <= 1'b0;
            dir_b_prev_reg <= 1'b0;
        end else if (i_ce) begin
            cs_prev_reg <= cs_n_s;
            ext_prev_reg <= ext_clk_s;
            dir_a_prev_reg <= dir_a_s;
            dir_b_prev_reg <= dir_b_s;
            if (commit) begin
                rx_seen_reg <= rx_tog_s;
            end
        end
    end

    assign cs_fall = cs_prev_reg & ~cs_n_s;
    // a word counts only if sixteen bits arrived before the select rose
    assign commit = ~cs_prev_reg & cs_n_s & (rx_tog_s != rx_seen_reg);
    assign ext_edge = ext_clk_s & ~ext_prev_reg;
    assign dir_rise = (dir_a_s & ~dir_a_prev_reg) | (dir_b_s & ~dir_b_prev_reg);
    assign rx_addr = rx_hold_reg[ADDR_LSB +: ADDR_W];

    // ---- serially written registers ----
    logic [3:0] read_sel_reg;
    logic [8:0] ch_ctrl_reg;
    logic [7:0] duty_reg [2];
    logic [7:0] delay_reg [2];

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            read_sel_reg <= READ_SEL_RST;
            ch_ctrl_reg <= CH_CTRL_RST;
            duty_reg <= '{DUTY_RST, DUTY_RST};
            delay_reg <= '{DELAY_RST, DELAY_RST};
        end else if (i_ce) begin
            if (!rst_s) begin
                read_sel_reg <= READ_SEL_RST;
                ch_ctrl_reg <= CH_CTRL_RST;
                duty_reg <= '{DUTY_RST, DUTY_RST};
                delay_reg <= '{DELAY_RST, DELAY_RST};
            end else if (commit) begin
                case (rx_addr)
                    ADDR_READ_SEL: read_sel_reg <= rx_hold_reg[3:0];
                    ADDR_CH_CTRL: ch_ctrl_reg <= rx_hold_reg[DATA_W-1:0];
                    ADDR_DUTY_A: duty_reg[0] <= rx_hold_reg[PWM_W-1:0];
                    ADDR_DUTY_B: duty_reg[1] <= rx_hold_reg[PWM_W-1:0];
                    ADDR_DELAY_A: delay_reg[0] <= rx_hold_reg[PWM_W-1:0];
                    ADDR_DELAY_B: delay_reg[1] <= rx_hold_reg[PWM_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // ---- watchdog ----
    logic wdog_last_reg, comm_lost_reg;
    logic [31:0] wdog_cnt_reg;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wdog_last_reg <= 1'b0;
            wdog_cnt_reg <= 32'h0000_0000;
            comm_lost_reg <= 1'b0;
        end else if (i_ce) begin
            if (!rst_s) begin
                wdog_last_reg <= 1'b0;
                wdog_cnt_reg <= 32'h0000_0000;
                comm_lost_reg <= 1'b0;
            end else if (commit && rx_hold_reg[WDOG_BIT] != wdog_last_reg) begin
                wdog_last_reg <= rx_hold_reg[WDOG_BIT];
                wdog_cnt_reg <= 32'h0000_0000;
            end else if (wdog_cnt_reg >= 32'(WDOG_CYC - 1)) begin
                comm_lost_reg <= 1'b1;
            end else begin
                wdog_cnt_reg <= wdog_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // ---- external clock monitor ----
    logic [31:0] mon_cnt_reg;
    logic clk_fail_reg;
    logic ext_used;

    assign ext_used = ch_ctrl_reg[CTRL_EXTCLK_A] | ch_ctrl_reg[CTRL_EXTCLK_B];

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mon_cnt_reg <= 32'h0000_0000;
            clk_fail_reg <= 1'b0;
        end else if (i_ce) begin
            if (!ext_used || ext_edge) begin
                mon_cnt_reg <= 32'h0000_0000;
                clk_fail_reg <= 1'b0;
            end else if (mon_cnt_reg >= 32'(CLKMON_LIMIT - 1)) begin
                clk_fail_reg <= 1'b1;
            end else begin
                mon_cnt_reg <= mon_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // ---- pwm ----
    logic [15:0] tick_cnt_reg;
    logic [7:0] int_phase_reg, ext_phase_reg;
    logic [1:0] pwm_on_reg;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tick_cnt_reg <= 16'h0000;
            int_phase_reg <= 8'h00;
            ext_phase_reg <= 8'h00;
        end else if (i_ce) begin
            if (tick_cnt_reg == 16'(PWM_TICK_CYC - 1)) begin
                tick_cnt_reg <= 16'h0000;
                int_phase_reg <= int_phase_reg + 8'h01;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 16'h0001;
            end
            if (ext_edge) begin
                ext_phase_reg <= ext_phase_reg + 8'h01;
            end
        end
    end

    for (genvar ch = 0; ch < 2; ch++) begin : g_pwm
        logic [7:0] phase;
        logic [7:0] pos;
        assign phase = ch_ctrl_reg[CTRL_EXTCLK_A + ch] ? ext_phase_reg : int_phase_reg;
        // delay shifts the on window inside the period, duty sets its length
        assign pos = phase - delay_reg[ch];
        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                pwm_on_reg[ch] <= 1'b0;
            end else if (i_ce) begin
                pwm_on_reg[ch] <= (pos < duty_reg[ch]);
            end
        end
    end

    // ---- operating state ----
    swcw_state_t state_reg;
    logic [31:0] sleep_cnt_reg;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= PS_SLEEP;
        end else if (i_ce) begin
            case (state_reg)
                PS_SLEEP: begin
                    if (rst_s) begin
                        state_reg <= PS_NORMAL;
                    end else if (dir_rise) begin
                        state_reg <= PS_DIRECT;
                    end
                end
                PS_DIRECT: begin
                    if (rst_s) begin
                        state_reg <= PS_NORMAL;
                    end else if (!dir_a_s && !dir_b_s
                                 && sleep_cnt_reg >= 32'(SLEEP_CYC - 1)) begin
                        state_reg <= PS_SLEEP;
                    end
                end
                PS_NORMAL: begin
                    if (!rst_s) begin
                        state_reg <= PS_DIRECT;
                    end else if (comm_lost_reg) begin
                        state_reg <= PS_FAILSAFE;
                    end
                end
                PS_FAILSAFE: begin
                    if (!rst_s) begin
                        state_reg <= PS_DIRECT;
                    end
                end
                default: state_reg <= PS_SLEEP;
            endcase
        end
    end

    // delay restarts on every active input, so it runs from the last fall
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sleep_cnt_reg <= 32'h0000_0000;
        end else if (i_ce) begin
            if (state_reg != PS_DIRECT || dir_a_s || dir_b_s) begin
                sleep_cnt_reg <= 32'h0000_0000;
            end else if (sleep_cnt_reg < 32'(SLEEP_CYC - 1)) begin
                sleep_cnt_reg <= sleep_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // ---- faults and readout ----
    logic [FLT_W-1:0] live_flt, sticky_reg;
    logic [8:0] rd_data;
    logic [15:0] rd_word;

    assign live_flt = {clk_fail_reg, sup_s.supply_too_low, sup_s.supply_too_high, flt_b_s, flt_a_s};

    always_comb begin
        case (read_sel_reg)
            RD_STATUS: rd_data = {comm_lost_reg, ~vdd_s, rst_s, o_awake, 2'b00, sticky_reg[14:12]};
            RD_FAULT_A: rd_data = {5'h00, sticky_reg[5:2]};
            RD_FAULT_B: rd_data = {5'h00, sticky_reg[11:8]};
            RD_DIAG_A: rd_data = {7'h00, sticky_reg[1:0]};
            RD_DIAG_B: rd_data = {7'h00, sticky_reg[7:6]};
            default: rd_data = 9'h000;
        endcase
        rd_word = (read_sel_reg == RD_ECHO) ? rx_hold_reg : {3'h0, read_sel_reg, rd_data};
    end

    // a fault arriving in the clearing cycle survives: set wins over clear
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sticky_reg <= 15'h0000;
            tx_word_reg <= 16'h0000;
        end else if (i_ce) begin
            if (cs_fall && vdd_s) begin
                tx_word_reg <= rd_word;
                sticky_reg <= (sticky_reg & ~clr_mask(read_sel_reg)) | live_flt;
            end else begin
                sticky_reg <= sticky_reg | live_flt;
            end
        end
    end

    // ---- pins ----
    logic out_a_next, out_b_next;

    always_comb begin
        case (state_reg)
            PS_NORMAL: begin
                out_a_next = ch_ctrl_reg[CTRL_PWM_A] ? pwm_on_reg[0] : dir_a_s;
                out_b_next = ch_ctrl_reg[CTRL_PWM_B] ? pwm_on_reg[1] : dir_b_s;
            end
            PS_DIRECT, PS_FAILSAFE: begin
                out_a_next = dir_a_s;
                out_b_next = dir_b_s;
            end
            default: begin
                out_a_next = 1'b0;
                out_b_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_power_output_a <= 1'b0;
            o_power_output_b <= 1'b0;
            o_motor_profile <= 2'b11;
            o_fault_flag_n_oe_n <= 1'b1;
            o_failsafe_flag_n_oe_n <= 1'b1;
            o_so_oe_n <= 1'b1;
        end else if (i_ce) begin
            o_power_output_a <= out_a_next;
            o_power_output_b <= out_b_next;
            o_motor_profile <= load_sel_s | ~load_conn_s;
            o_fault_flag_n_oe_n <= ~(|live_flt[14:12] | |flt_a_s | |flt_b_s);
            o_failsafe_flag_n_oe_n <= ~(comm_lost_reg | ~vdd_s);
            o_so_oe_n <= cs_n_s | ~vdd_s;
        end
    end

    // open-drain flags only ever pull low
    assign o_fault_flag_n_drv = 1'b0;
    assign o_failsafe_flag_n_drv = 1'b0;
    assign o_awake = (state_reg != PS_SLEEP);

    // ---- checks ----
    direct_follow_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && state_reg == PS_DIRECT) |=> o_power_output_a == $past(dir_a_s))
        else $error("channel a does not follow its direct input");
    wake_on_rise_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && state_reg == PS_SLEEP && !rst_s && dir_rise) |=> state_reg == PS_DIRECT)
        else $error("rising direct input did not wake the device");
    sleep_delay_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == PS_SLEEP && $past(state_reg) == PS_DIRECT)
        |-> $past(sleep_cnt_reg) == 32'(SLEEP_CYC - 1))
        else $error("sleep entered before the delay elapsed");
    held_regs_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && !rst_s) |=> (ch_ctrl_reg == CH_CTRL_RST && duty_reg[0] == DUTY_RST))
        else $error("registers not held while external reset low");
    wdog_timeout_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(comm_lost_reg) |-> $past(wdog_cnt_reg) == 32'(WDOG_CYC - 1) && $past(rst_s))
        else $error("link loss declared at the wrong time");
    sticky_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && live_flt[2]) |=> sticky_reg[2])
        else $error("fault lost while being cleared");
    write_duty_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && rst_s && commit && rx_addr == ADDR_DUTY_A)
        |=> duty_reg[0] == $past(rx_hold_reg[7:0]))
        else $error("addressed register not written at select rise");
    so_float_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && cs_n_s) |=> o_so_oe_n)
        else $error("serial output driven while deselected");
    failsafe_vdd_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && !vdd_s) |=> !o_failsafe_flag_n_oe_n)
        else $error("failsafe flag not low without logic supply");
    fault_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && clk_fail_reg) |=> !o_fault_flag_n_oe_n)
        else $error("fault flag not low on clock failure");

endmodule // swcw_top

`default_nettype wire

// [hw/swcw_pkg.sv]
// constants and types shared by the switch control front end
package swcw_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int WORD_W = 16;
    localparam int WDOG_BIT = 15;
    localparam int ADDR_LSB = 9;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 9;
    localparam int PWM_W = 8;
    localparam int PWM_STEPS = 256;
    localparam int PWM_MAX_HZ = 1000;
    // least step period, rounded up so the frame rate never exceeds the maximum
    localparam int PWM_TICK_CYC = (CLK_HZ + PWM_MAX_HZ * PWM_STEPS - 1) / (PWM_MAX_HZ * PWM_STEPS);
    localparam int SLEEP_DELAY_US = 200;
    localparam int SLEEP_DELAY_CYC = SLEEP_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int WDOG_TIMEOUT_MS = 32;
    localparam int WDOG_TIMEOUT_CYC = WDOG_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int CLKMON_US = 100;
    localparam int CLKMON_CYC = CLKMON_US * (CLK_HZ / 1_000_000);
    // register addresses in frame bits 12..9
    localparam logic [3:0] ADDR_READ_SEL = 4'h0;
    localparam logic [3:0] ADDR_CH_CTRL = 4'h1;
    localparam logic [3:0] ADDR_DUTY_A = 4'h2;
    localparam logic [3:0] ADDR_DUTY_B = 4'h3;
    localparam logic [3:0] ADDR_DELAY_A = 4'h4;
    localparam logic [3:0] ADDR_DELAY_B = 4'h5;
    // readout selections
    localparam logic [3:0] RD_STATUS = 4'h0;
    localparam logic [3:0] RD_FAULT_A = 4'h1;
    localparam logic [3:0] RD_FAULT_B = 4'h2;
    localparam logic [3:0] RD_DIAG_A = 4'h3;
    localparam logic [3:0] RD_DIAG_B = 4'h4;
    localparam logic [3:0] RD_ECHO = 4'h5;
    // channel control field positions
    localparam int CTRL_PWM_A = 0;
    localparam int CTRL_PWM_B = 1;
    localparam int CTRL_EXTCLK_A = 2;
    localparam int CTRL_EXTCLK_B = 3;
    // reset contents
    localparam logic [3:0] READ_SEL_RST = 4'h0;
    localparam logic [8:0] CH_CTRL_RST = 9'h000;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [7:0] DELAY_RST = 8'h00;
    // sticky fault vector: [5:0] chan a, [11:6] chan b, 12 high, 13 low, 14 clock fail
    localparam int FLT_W = 15;
    localparam logic [14:0] CLR_STATUS = 15'h7000;
    localparam logic [14:0] CLR_FAULT_A = 15'h003C;
    localparam logic [14:0] CLR_FAULT_B = 15'h0F00;
    localparam logic [14:0] CLR_DIAG_A = 15'h0003;
    localparam logic [14:0] CLR_DIAG_B = 15'h00C0;
    // pin synchroniser width and reset, chip select idles high
    localparam int SYNC_W = 25;
    localparam logic [24:0] SYNC_RST = 25'h0000002;

    typedef struct packed {
        logic overcurrent_fault;
        logic overheat_fault;
        logic short_to_supply;
        logic severe_short_fault;
        logic open_load_driven;
        logic open_load_idle;
    } swcw_chfault_t;

    typedef struct packed {
        logic supply_too_high;
        logic supply_too_low;
    } swcw_supply_t;

    typedef enum logic [1:0] {PS_SLEEP, PS_DIRECT, PS_NORMAL, PS_FAILSAFE} swcw_state_t;
endpackage

// [test/swcw_host.sv]
// host serial master model driving the link of the switch control front end
`timescale 1ns/1ps
`default_nettype none
module swcw_host (
    // serial link
    output var logic o_sclk,
    output var logic o_csn,
    output var logic o_si,
    input wire logic i_so
);
    initial begin
        o_sclk = 1'b0;
        o_csn = 1'b1;
        o_si = 1'b0;
    end
    // clock only runs inside a frame; 30 ns period
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        o_csn = 1'b0;
        #500;
        for (int i = 15; i >= 0; i--) begin
            o_sclk = 1'b1;
            o_si = tx[i];
            #15;
            rx[i] = i_so;
            o_sclk = 1'b0;
            #15;
        end
        #60;
        o_csn = 1'b1;
        o_si = ~o_si; // released line must not show the last bit
        #100;
    endtask
endmodule // swcw_host
`default_nettype wire

// [test/test_switch_spi_control_watchdog.sv]
// self-checking bench for the switch control front end
`timescale 1ns/1ps
`default_nettype none
module test_switch_spi_control_watchdog;
    import swcw_pkg::*;
    logic clk = 1'b0, rst = 1'b1, din_a = 1'b0, din_b = 1'b0, ext_rst_n = 1'b0;
    logic [1:0] sel = 2'b01, conn = 2'b10, prof;
    swcw_chfault_t flt_a = '0, flt_b = '0;
    swcw_supply_t sup = '0;
    logic vdd = 1'b1, ext_clk = 1'b0;
    logic sclk, csn, si, so, so_oe_n, pwr_a, pwr_b, flt_oe_n, fs_oe_n, awake;
    logic [15:0] rx;
    wire logic so_w = so_oe_n ? 1'bz : so;
    int fails = 0, n_checks = 0;
    always #2.5 clk = ~clk;
    swcw_top #(.SLEEP_CYC(50), .WDOG_CYC(2000), .CLKMON_LIMIT(40)) i_swcw_top (
        .i_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_direct_in_a(din_a), .i_direct_in_b(din_b),
        .i_load_sel(sel), .i_load_sel_conn(conn), .i_external_reset_n(ext_rst_n),
        .i_logic_supply_ok(vdd), .i_pwm_ext_clk(ext_clk), .i_fault_a(flt_a), .i_fault_b(flt_b),
        .i_supply(sup), .i_sclk(sclk), .i_chip_select_n(csn), .i_si(si), .o_so(so),
        .o_so_oe_n(so_oe_n), .o_power_output_a(pwr_a), .o_power_output_b(pwr_b),
        .o_motor_profile(prof), .o_fault_flag_n_drv(), .o_fault_flag_n_oe_n(flt_oe_n),
        .o_failsafe_flag_n_drv(), .o_failsafe_flag_n_oe_n(fs_oe_n), .o_awake(awake));
    swcw_host i_swcw_host (.o_sclk(sclk), .o_csn(csn), .o_si(si), .i_so(so_w));
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: pick = pwr_a & pwr_b;
            1: pick = flt_oe_n;
            2: pick = fs_oe_n;
            default: pick = awake;
        endcase
    endfunction
    // bounded wait; running out ends the run
    task automatic wt(input string nm, input int s, input logic e);
        int k;
        for (k = 0; k < 5000 && pick(s) !== e; k++)
            @(negedge clk);
        chk(nm, {15'h0000, pick(s)}, {15'h0000, e});
        if (k == 5000) begin
            fails++;
            summarize();
        end
    endtask
    task automatic t_spi();
        i_swcw_host.xfer(16'h8005, rx);
        i_swcw_host.xfer(16'h0005, rx);
        chk("echo word", rx, 16'h8005);
        chk("so idle", {15'h0000, so_oe_n}, 16'h0001);
        $display("test spi done");
    endtask
    task automatic t_direct();
        @(negedge clk);
        din_a = 1'b1;
        din_b = 1'b1;
        wt("channels on", 0, 1'b1);
        din_a = 1'b0;
        din_b = 1'b0;
        wt("channels off", 0, 1'b0);
        chk("profile", {14'h0000, prof}, 16'h0001);
        $display("test direct done");
    endtask
    task automatic t_fault();
        @(negedge clk);
        flt_a.overheat_fault = 1'b1;
        wt("fault flag set", 1, 1'b0);
        flt_a.overheat_fault = 1'b0;
        wt("fault flag clear", 1, 1'b1);
        flt_b.severe_short_fault = 1'b1;
        wt("fault b flag set", 1, 1'b0);
        flt_b.severe_short_fault = 1'b0;
        wt("fault b flag clear", 1, 1'b1);
        sup.supply_too_low = 1'b1;
        wt("supply flag set", 1, 1'b0);
        sup.supply_too_low = 1'b0;
        wt("supply flag clear", 1, 1'b1);
        $display("test fault done");
    endtask
    // channel a on pwm with external clock: duty, delay, clock steps, monitor
    task automatic t_pwm();
        din_a = 1'b1;
        i_swcw_host.xfer(16'h8205, rx);
        chk("pwm a idle", {15'h0000, pwr_a}, 16'h0000);
        wt("clock fail", 1, 1'b0);
        i_swcw_host.xfer(16'h0402, rx);
        chk("pwm a duty", {15'h0000, pwr_a}, 16'h0001);
        repeat (2) begin
            ext_clk = 1'b1;
            repeat (4) @(negedge clk);
            ext_clk = 1'b0;
            repeat (4) @(negedge clk);
        end
        chk("pwm a step", {15'h0000, pwr_a}, 16'h0000);
        i_swcw_host.xfer(16'h8802, rx);
        chk("pwm a delay", {15'h0000, pwr_a}, 16'h0001);
        i_swcw_host.xfer(16'h0200, rx);
        din_a = 1'b0;
        wt("clock fail cleared", 1, 1'b1);
        $display("test pwm done");
    endtask
    // logic supply lost: failsafe low, readout floats
    task automatic t_supply();
        vdd = 1'b0;
        wt("failsafe no supply", 2, 1'b0);
        i_swcw_host.xfer(16'h8000, rx);
        chk("so unreadable", rx, 16'hZZZZ);
        vdd = 1'b1;
        wt("failsafe supply back", 2, 1'b1);
        $display("test supply done");
    endtask
    // no further toggle, then external reset low, sleep and wake
    task automatic t_wdog();
        wt("link lost", 2, 1'b0);
        ext_rst_n = 1'b0;
        wt("lost cleared", 2, 1'b1);
        wt("asleep", 3, 1'b0);
        din_a = 1'b1;
        wt("woken", 3, 1'b1);
        $display("test watchdog done");
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        ext_rst_n = 1'b1;
        repeat (10) @(negedge clk);
        t_spi();
        t_direct();
        t_fault();
        t_pwm();
        t_supply();
        t_wdog();
        summarize();
    end
endmodule // test_switch_spi_control_watchdog
`default_nettype wire
